// [src/dbseq_core.v]
// program sequencer branch control: delayed and immediate branches,
// pc stack effects inside delay slots, interrupt hold-off
// assumes decode presents one instruction per cycle with exec_adv
`timescale 1ns/1ps
`include "dbseq_consts.vh"

// Functional notes
// - a delayed jump or call runs both slot instructions, aborts the third, loses one cycle.
// - a delayed call pushes the address three past the call as its return.
// - a delayed branch and its slots are atomic; interrupts wait latched until it ends.
// - stack top and pointer reads in a slot already show the branch push or pop.
// - an idle in a slot stays idle since wake interrupts are held off.
// - back-to-back conditional delayed branches work when at most one is taken.
// - a delayed jump in the first slot restarts the group: two more slots run, then it goes to its own target.
// - a taken equal jump followed by a not-equal delayed jump makes the second a no-op.
// - an explicit push in a call slot lands above the return address.
// - an explicit pop in a slot discards the fresh return address, unprotected.
// - a top write in a jump slot with a non-empty stack replaces the top entry.
// - a top write in a jump slot with an empty stack does nothing.
// - a top write in a call slot overrides the call's automatic push.
// - an undelayed branch aborts fetch1, fetch2 and decode, losing three cycles.
// - a delayed call pushes its return address as the call is decoded.
module dbseq_core #(
  parameter AW  = `DBSEQ_AW,
  parameter SPW = `DBSEQ_SPW
) (
  input  wire           clk,
  input  wire           reset_n,
  input  wire           exec_adv,
  input  wire [AW-1:0]  dec_pc,
  input  wire           dec_branch,
  input  wire           dec_call,
  input  wire           dec_rts,
  input  wire           dec_delay_slot_modifier,
  input  wire [1:0]     dec_cond,
  input  wire           dec_cond_true,
  input  wire [AW-1:0]  dec_target,
  input  wire           dec_push,
  input  wire           dec_pop,
  input  wire           dec_wr_top,
  input  wire [AW-1:0]  dec_wr_data,
  input  wire           dec_idle,
  input  wire           irq_pending,
  output reg            redirect_r,
  output reg  [AW-1:0]  redirect_pc_r,
  output reg  [1:0]     squash_cnt_r,
  output reg            irq_accept_r,
  output reg            irq_hold_r,
  output reg            idle_r,
  output reg            in_slot_r,
  output reg  [AW-1:0]  pc_stack_top_reg,
  output reg  [SPW-1:0] pc_stack_pointer_reg
);

  // ----------------------------------------------------------------
  // decode-stage branch qualification
  // ----------------------------------------------------------------
  wire          slot_busy;
  wire [1:0]    slot_left;
  wire          eq_taken_r_hit;
  wire          br_taken;
  wire          db_taken;
  wire          imm_taken;
  wire          stk_push;
  wire [AW-1:0] stk_push_data;
  wire          stk_pop;
  wire          stk_wr;
  wire [AW-1:0] stk_top;
  wire [SPW-1:0] stk_ptr;

  reg           eq_taken_r;
  reg           pend_r;
  reg  [AW-1:0] pend_pc_r;
  reg  [1:0]    pend_wait_r;

  // not-equal jump right behind a taken equal jump is a no-op
  assign eq_taken_r_hit = eq_taken_r && (dec_cond == `DBSEQ_CND_NE);

  // only one of two exclusive conditional branches is taken
  assign br_taken  = dec_branch && exec_adv && dec_cond_true
                     && !eq_taken_r_hit;
  assign db_taken  = br_taken && dec_delay_slot_modifier;
  assign imm_taken = br_taken && !dec_delay_slot_modifier;

  // remember a taken delayed equal jump for one decode slot
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      eq_taken_r <= 1'b0;
    else if (exec_adv)
      eq_taken_r <= db_taken && (dec_cond == `DBSEQ_CND_EQ);
  end

  // ----------------------------------------------------------------
  // slot counter and atomic group
  // ----------------------------------------------------------------
  dbseq_slot_cnt u_slot (
    .clk      (clk),
    .reset_n  (reset_n),
    .start    (db_taken),
    .exec_adv (exec_adv),
    .left_r   (slot_left),
    .busy_r   (slot_busy)
  );

  // ----------------------------------------------------------------
  // pc stack request merge
  // ----------------------------------------------------------------
  // the call push is made at decode so slot reads already see it;
  // a slot push simply stacks on top of it, a slot pop removes it
  assign stk_push = (br_taken && dec_call)
                    || (dec_push && exec_adv);
  assign stk_push_data = (br_taken && dec_call)
                         ? (db_taken ? dec_pc + `DBSEQ_RET_OFS
                                     : dec_pc + `DBSEQ_IMM_RET_OFS)
                         : dec_pc;
  // explicit pop in a slot is passed through unguarded
  assign stk_pop = (dec_pop && exec_adv)
                   || (br_taken && dec_rts);
  // top write in a slot: replaces top, or the call push; empty = none
  assign stk_wr  = dec_wr_top && exec_adv;

  dbseq_pc_stack #(
    .AW    (AW),
    .SPW   (SPW),
    .DEPTH (`DBSEQ_DEPTH)
  ) u_stack (
    .clk       (clk),
    .reset_n   (reset_n),
    .push      (stk_push),
    .push_data (stk_push_data),
    .pop       (stk_pop),
    .wr_top    (stk_wr),
    .wr_data   (dec_wr_data),
    .top_r     (stk_top),
    .ptr_r     (stk_ptr)
  );

  // stack readout registered each cycle; slot reads see the push
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_stack_top_reg     <= {AW{1'b0}};
      pc_stack_pointer_reg <= {SPW{1'b0}};
    end
    else
    begin
      pc_stack_top_reg     <= stk_top;
      pc_stack_pointer_reg <= stk_ptr;
    end
  end

  // ----------------------------------------------------------------
  // redirect scheduling
  // ----------------------------------------------------------------
  // a delayed branch waits for two slot instructions; a new delayed
  // branch in a slot replaces the pending target and restarts
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_r      <= 1'b0;
      pend_pc_r   <= {AW{1'b0}};
      pend_wait_r <= 2'h0;
    end
    else if (db_taken)
    begin
      pend_r      <= 1'b1;
      pend_pc_r   <= dec_target;
      pend_wait_r <= `DBSEQ_SLOTS;
    end
    else if (pend_r && exec_adv)
    begin
      if (pend_wait_r == 2'h1)
        pend_r <= 1'b0;
      pend_wait_r <= pend_wait_r - 2'h1;
    end
  end

  // redirect pulse and squash count toward fetch
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      redirect_r    <= 1'b0;
      redirect_pc_r <= {AW{1'b0}};
      squash_cnt_r  <= 2'h0;
    end
    else if (imm_taken)
    begin
      redirect_r    <= 1'b1;
      redirect_pc_r <= dec_rts ? stk_top : dec_target;
      squash_cnt_r  <= `DBSEQ_IMM_LOST;
    end
    else if (pend_r && exec_adv && pend_wait_r == 2'h1)
    begin
      redirect_r    <= 1'b1;
      redirect_pc_r <= pend_pc_r;
      squash_cnt_r  <= 2'h1;
    end
    else
    begin
      redirect_r    <= 1'b0;
      squash_cnt_r  <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt hold-off and idle
  // ----------------------------------------------------------------
  // group is busy from branch decode until both slots leave execute
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_hold_r   <= 1'b0;
      irq_accept_r <= 1'b0;
      in_slot_r    <= 1'b0;
    end
    else
    begin
      irq_hold_r   <= db_taken || slot_busy;
      irq_accept_r <= irq_pending && !db_taken && !slot_busy
                      && !irq_accept_r;
      in_slot_r    <= slot_left != 2'h0;
    end
  end

  // idle ends only on a pending interrupt, never inside a group
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      idle_r <= 1'b0;
    else if (dec_idle && exec_adv)
      idle_r <= 1'b1;
    else if (irq_pending && !slot_busy && !db_taken)
      idle_r <= 1'b0;
  end

endmodule // dbseq_core

// [include/dbseq_consts.vh]
// constants for the delayed branch sequencer
// assumes inclusion by the sequencer modules only
`ifndef DBSEQ_CONSTS_VH
`define DBSEQ_CONSTS_VH

// ----------------------------------------------------------------
// widths and depths
// ----------------------------------------------------------------
`define DBSEQ_AW          24
`define DBSEQ_SPW         5
`define DBSEQ_DEPTH       30

// ----------------------------------------------------------------
// pipeline timing
// ----------------------------------------------------------------
`define DBSEQ_SLOTS       2'd2
`define DBSEQ_IMM_LOST    2'd3
`define DBSEQ_RET_OFS     24'h000003
`define DBSEQ_IMM_RET_OFS 24'h000001

// ----------------------------------------------------------------
// condition codes seen by the sequencer
// ----------------------------------------------------------------
`define DBSEQ_CND_ALWAYS  2'h0
`define DBSEQ_CND_EQ      2'h1
`define DBSEQ_CND_NE      2'h2
`define DBSEQ_CND_OTHER   2'h3

`endif

// [src/dbseq_pc_stack.v]
// pc stack storage with registered top-of-stack read
// assumes the sequencer resolves push, pop and top writes per cycle
`timescale 1ns/1ps
`include "dbseq_consts.vh"

module dbseq_pc_stack #(
  parameter AW    = `DBSEQ_AW,
  parameter SPW   = `DBSEQ_SPW,
  parameter DEPTH = `DBSEQ_DEPTH
) (
  input  wire           clk,
  input  wire           reset_n,
  input  wire           push,
  input  wire [AW-1:0]  push_data,
  input  wire           pop,
  input  wire           wr_top,
  input  wire [AW-1:0]  wr_data,
  output reg  [AW-1:0]  top_r,
  output reg  [SPW-1:0] ptr_r
);

  reg [AW-1:0] mem [0:DEPTH-1];
  reg [SPW-1:0] ptr_nxt;

  // ----------------------------------------------------------------
  // pointer update
  // ----------------------------------------------------------------
  // overflow is not guarded, software owns that; a pop at zero leaves the pointer at zero
  always @*
  begin
    ptr_nxt = ptr_r;
    if (push && !pop)
      ptr_nxt = ptr_r + 1'b1;
    else if (pop && !push && ptr_r != {SPW{1'b0}})
      ptr_nxt = ptr_r - 1'b1;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ptr_r <= {SPW{1'b0}};
    else
      ptr_r <= ptr_nxt;
  end

  // ----------------------------------------------------------------
  // storage and top readout
  // ----------------------------------------------------------------
  // a top write lands after a push of the same cycle, so it wins
  always @(posedge clk)
  begin
    if (push && !pop)
      mem[ptr_r] <= wr_top ? wr_data : push_data;
    else if (wr_top && ptr_r != {SPW{1'b0}})
      mem[ptr_r - 1'b1] <= wr_data;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      top_r <= {AW{1'b0}};
    else if (push && !pop)
      top_r <= wr_top ? wr_data : push_data;
    else if (wr_top && ptr_r != {SPW{1'b0}})
      top_r <= wr_data;
    else if (pop && ptr_nxt != {SPW{1'b0}})
      top_r <= mem[ptr_nxt - 1'b1];
    else if (pop)
      top_r <= {AW{1'b0}};
  end

endmodule // dbseq_pc_stack

// [src/dbseq_slot_cnt.v]
// counter of delay-slot instructions still to leave execute
// assumes start pulses come from decode of a taken delayed branch
`timescale 1ns/1ps
`include "dbseq_consts.vh"

module dbseq_slot_cnt (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       start,
  input  wire       exec_adv,
  output reg  [1:0] left_r,
  output reg        busy_r
);

  reg [1:0] left_nxt;

  // ----------------------------------------------------------------
  // count down one per instruction leaving execute
  // ----------------------------------------------------------------
  // a restart reloads, so a branch in a slot extends the group
  always @*
  begin
    left_nxt = left_r;
    if (start)
      left_nxt = `DBSEQ_SLOTS;
    else if (exec_adv && left_r != 2'h0)
      left_nxt = left_r - 2'h1;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      left_r <= 2'h0;
      busy_r <= 1'b0;
    end
    else
    begin
      left_r <= left_nxt;
      busy_r <= (left_nxt != 2'h0);
    end
  end

endmodule // dbseq_slot_cnt

// [tb/dbseq_core_sva.sv]
// port-level timing checks for the branch sequencer core
// assumes a bind onto dbseq_core, single clock domain
`timescale 1ns/1ps
module dbseq_core_sva #(
  parameter AW  = 24,
  parameter SPW = 5
) (
  input wire           clk,
  input wire           reset_n,
  input wire           exec_adv,
  input wire [AW-1:0]  dec_pc,
  input wire           dec_branch,
  input wire           dec_call,
  input wire           dec_rts,
  input wire           dec_delay_slot_modifier,
  input wire           dec_cond_true,
  input wire [AW-1:0]  dec_target,
  input wire           dec_push,
  input wire           dec_pop,
  input wire           dec_wr_top,
  input wire           redirect_r,
  input wire [AW-1:0]  redirect_pc_r,
  input wire [1:0]     squash_cnt_r,
  input wire           irq_accept_r,
  input wire           irq_hold_r,
  input wire           idle_r,
  input wire           in_slot_r,
  input wire [AW-1:0]  pc_stack_top_reg,
  input wire [SPW-1:0] pc_stack_pointer_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // branch taken outside any running group
  // ----------------------------------------
  sequence s_take;
    dec_branch && exec_adv && dec_cond_true && !irq_hold_r && !in_slot_r;
  endsequence
  sequence s_db;
    s_take ##0 dec_delay_slot_modifier;
  endsequence
  sequence s_call;
    s_db ##0 (dec_call && !dec_wr_top && !dec_push && !dec_pop);
  endsequence
  property p_imm;
    s_take ##0 (!dec_delay_slot_modifier && !dec_rts) |=> redirect_r &&
      squash_cnt_r == 2'd3 && redirect_pc_r == $past(dec_target);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate redirect");
  property p_db;
    s_db |-> ##[1:6] (redirect_r && squash_cnt_r == 2'd1);
  endproperty
  a_db: assert property (p_db) else $error("delayed redirect");
  property p_hold;
    s_db |=> irq_hold_r;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_noacc;
    irq_hold_r |-> !irq_accept_r;
  endproperty
  a_noacc: assert property (p_noacc) else $error("accept in group");
  property p_pulse;
    redirect_r |=> !redirect_r;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long redirect");
  property p_ret;
    s_call |-> ##2 pc_stack_top_reg == $past(dec_pc, 2) + 24'h000003;
  endproperty
  a_ret: assert property (p_ret) else $error("return address");
  property p_ptr;
    s_call ##0 pc_stack_pointer_reg < 5'd29 |-> ##2
      pc_stack_pointer_reg == $past(pc_stack_pointer_reg, 1) + 5'd1;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer");
  property p_idle;
    idle_r ##1 irq_hold_r |-> idle_r;
  endproperty
  a_idle: assert property (p_idle) else $error("idle left");
endmodule // dbseq_core_sva

bind dbseq_core dbseq_core_sva #(.AW(AW), .SPW(SPW)) dbseq_core_sva_i (.*);

// [tb/dbseq_core_bench.sv]
// self-checking bench for the branch sequencer core
// assumes dbseq_core from src/, 40 MHz clock
`timescale 1ns/1ps
module dbseq_core_bench;
  reg         clk, reset_n, br, cl, db, ct, wt, irq;
  reg  [1:0]  cd;
  reg         ph, pp, id;
  reg  [23:0] pc, tg, wd, l_pc;
  reg  [1:0]  l_sq;
  wire        rd, acc, hold, idr, slot;
  wire [23:0] rpc, top;
  wire [1:0]  sq;
  wire [4:0]  ptr;
  integer     err_total, total_checks, n_rd, n_early, n_acc;
  // exec_adv held high: one instruction per cycle
  dbseq_core dbseq_core_i (.clk(clk), .reset_n(reset_n), .exec_adv(1'b1),
    .dec_pc(pc), .dec_branch(br), .dec_call(cl), .dec_rts(1'b0),
    .dec_delay_slot_modifier(db), .dec_cond(cd), .dec_cond_true(ct),
    .dec_target(tg), .dec_push(ph), .dec_pop(pp), .dec_wr_top(wt),
    .dec_wr_data(wd), .dec_idle(id), .irq_pending(irq),
    .redirect_r(rd), .redirect_pc_r(rpc), .squash_cnt_r(sq),
    .irq_accept_r(acc), .irq_hold_r(hold), .idle_r(idr),
    .in_slot_r(slot), .pc_stack_top_reg(top), .pc_stack_pointer_reg(ptr));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task tally_and_finish;
  begin
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task chk(input ok, input string m);
  begin
    total_checks = total_checks + 1;
    if (ok !== 1'b1)
    begin
      err_total = err_total + 1;
      $display("[ERR] %0t %s", $time, m);
    end
  end
  endtask
  task rst;
  begin
    @(negedge clk) reset_n = 0;
    repeat (4) @(negedge clk);
    reset_n = 1;
  end
  endtask
  // one decoded instruction, driven at the falling edge
  task issue(input b, c, d, input [1:0] k, input t,
             input [23:0] p, g, input w, input [23:0] v);
  begin
    @(negedge clk);
    br = b; cl = c; db = d; cd = k; ct = t; pc = p; tg = g; wt = w; wd = v;
    @(posedge clk);
  end
  endtask
  // plain slots; counts redirects and accepts for ten cycles
  task watch(input i);
  begin
    @(negedge clk);
    br = 0; wt = 0; ct = 0; irq = i; n_rd = 0; n_early = 0; n_acc = 0;
    repeat (10)
    begin
      #1;
      if (rd === 1'b1)
      begin
        n_rd = n_rd + 1; l_pc = rpc; l_sq = sq;
      end
      if (acc === 1'b1)
        if (n_rd == 0) n_early = n_early + 1; else n_acc = n_acc + 1;
      @(posedge clk);
    end
    @(negedge clk) irq = 0;
  end
  endtask
  task t_call;
  begin
    rst;
    issue(1, 1, 1, 2'h0, 1, 24'h000100, 24'h000200, 0, 0);
    watch(1);
    chk(n_rd == 1 && l_pc === 24'h000200 && l_sq === 2'd1, "db");
    chk(top === 24'h000103, "ret");
    chk(ptr === 5'h01, "ptr");
    chk(n_early == 0 && n_acc > 0, "irq");
  end
  endtask
  task t_imm;
  begin
    rst;
    issue(1, 0, 0, 2'h0, 1, 24'h000050, 24'h000300, 0, 0);
    watch(0);
    chk(n_rd == 1 && l_pc === 24'h000300 && l_sq === 2'd3, "imm");
  end
  endtask
  task t_wr;
  begin
    rst;
    issue(1, 0, 1, 2'h0, 1, 24'h000010, 24'h000040, 0, 0);
    issue(0, 0, 0, 2'h0, 0, 24'h000011, 0, 1, 24'h5A5A5A);
    watch(0);
    chk(ptr === 5'h00 && n_rd == 1 && l_pc === 24'h000040, "empty");
    issue(1, 1, 1, 2'h0, 1, 24'h090100, 24'h080000, 0, 0);
    issue(0, 0, 0, 2'h0, 0, 24'h090101, 0, 1, 24'h090200);
    watch(0);
    chk(top === 24'h090200 && ptr === 5'h01, "callwr");
    issue(1, 0, 1, 2'h0, 1, 24'h080000, 24'h070000, 0, 0);
    issue(0, 0, 0, 2'h0, 0, 24'h080001, 0, 1, 24'h123456);
    watch(0);
    chk(top === 24'h123456 && ptr === 5'h01, "jumpwr");
  end
  endtask
  task t_pair;
  begin
    rst;
    issue(1, 0, 1, 2'h1, 1, 24'h000010, 24'h0000A0, 0, 0);
    issue(1, 0, 1, 2'h2, 1, 24'h000011, 24'h0000B0, 0, 0);
    watch(0);
    chk(n_rd == 1 && l_pc === 24'h0000A0, "eqne");
    rst;
    issue(1, 0, 1, 2'h3, 0, 24'h000010, 24'h0000A0, 0, 0);
    issue(1, 0, 1, 2'h3, 1, 24'h000011, 24'h0000B0, 0, 0);
    watch(0);
    chk(n_rd == 1 && l_pc === 24'h0000B0, "excl");
    rst;
    issue(1, 0, 1, 2'h0, 1, 24'h000010, 24'h0000A0, 0, 0);
    issue(1, 0, 1, 2'h0, 1, 24'h000011, 24'h0000B0, 0, 0);
    watch(0);
    chk(n_rd == 1 && l_pc === 24'h0000B0, "nest");
  end
  endtask
  // slot traffic of delayed calls: idle, explicit push, explicit pop
  task t_slot;
  begin
    rst;
    issue(1, 1, 1, 2'h0, 1, 24'h000200, 24'h000400, 0, 0);
    @(negedge clk);
    br = 0; ct = 0; id = 1; irq = 1; pc = 24'h000201;
    @(posedge clk);
    #1;
    chk(hold === 1'b1 && slot === 1'b1, "group");
    chk(ptr === 5'h01 && top === 24'h000203, "slotrd");
    @(negedge clk);
    id = 0; ph = 1; pc = 24'h000202;
    @(posedge clk);
    #1;
    chk(idr === 1'b1 && acc === 1'b0, "idle");
    @(negedge clk);
    ph = 0; irq = 0;
    @(posedge clk);
    #1;
    chk(ptr === 5'h02 && top === 24'h000202, "push");
    rst;
    issue(1, 1, 1, 2'h0, 1, 24'h000300, 24'h000500, 0, 0);
    @(negedge clk);
    br = 0; ct = 0; pp = 1;
    @(negedge clk);
    pp = 0;
    @(posedge clk);
    #1;
    chk(ptr === 5'h00 && top === 24'h000000, "pop");
  end
  endtask
  // watchdog: the whole run needs under two hundred cycles
  initial
  begin
    #(25 * 3000);
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial
  begin
    reset_n = 0; br = 0; cl = 0; db = 0; ct = 0; wt = 0; irq = 0;
    cd = 0; pc = 0; tg = 0; wd = 0; err_total = 0; total_checks = 0;
    ph = 0; pp = 0; id = 0;
    t_call;
    t_imm;
    t_wr;
    t_pair;
    t_slot;
    tally_and_finish;
  end
endmodule // dbseq_core_bench
